//--- src/amp_power_ident_registers.sv
// Amplifier control register bank: identification, power control, clipper, config one
//
// Contract
// - Offset zero reads fixed identifier, ignores writes
// - Power bits 7:2 hold threshold top, reset ones
// - Clip each sample magnitude to the threshold
// - Sleep ramps volume down, then stage off
// - Sleep keeps other blocks awake for restart
// - Power bit 1 selects sleep, resets zero
// - Shutdown when run bit low or pin low
// - Shutdown keeps I2C and register contents
// - Run bit resets one; writing one resumes
// - Reset loads defaults into every register
`timescale 1ns/1ps
`default_nettype none
module amp_power_ident_registers
   import amp_ctrl_pkg::*;
#(
   parameter logic [7:0] PART_ID_VALUE = 8'hA5,  // Arbitrary identifier value
   parameter logic [6:0] TARGET_ADDR   = 7'h2C,
   parameter int         SAMPLE_W      = 24
)
(
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst,
   // I2C pins
   input  wire logic                       scl_in,
   input  wire logic                       sda_in,
   output var  logic                       sda_out,
   output var  logic                       sda_oe,
   // Shutdown pin, active low
   input  wire logic                       shutdown_control_n,
   // Lower clipper threshold bits from the neighbouring registers
   input  wire logic [CLIP_LO_W-1:0]       clip_low_bits,
   // Audio path
   input  wire logic signed [SAMPLE_W-1:0] sample_in,
   input  wire logic                       sample_in_valid,
   output logic signed [SAMPLE_W-1:0]      sample_out,
   output logic                            sample_out_valid,
   // Power state
   output logic                            stage_enable,
   output logic                            stage_hiz,
   output logic                            core_awake,
   output logic [7:0]                      ramp_gain,
   // Digital configuration one
   output logic                            highpass_skip,
   output logic                            slot_choice_source,
   output logic                            rate_speed_select,
   output logic [2:0]                      serial_audio_framing
);

   logic [7:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic         reg_write;
   logic [7:0]   reg_rdata;
   logic [7:0]   power_and_clip_high_reg;
   logic [7:0]   digital_config_one_reg;
   logic [1:0]   pin_sync_reg;
   power_state_e state_reg;
   power_state_e state_next;
   logic [7:0]   gain_reg;
   logic [7:0]   gain_next;
   logic [15:0]  step_cnt_reg;

   i2c_reg_port #(
      .TARGET_ADDR (TARGET_ADDR)
   ) i2c_reg_port_inst (
      .clock     (clock),
      .rst       (rst),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .sda_out   (sda_out),
      .sda_oe    (sda_oe),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_write (reg_write),
      .reg_rdata (reg_rdata)
   );

   // Register file; the port stays alive in every power state
   wire wr_power = reg_write & (reg_addr == OFS_POWER);
   wire wr_dcfg1 = reg_write & (reg_addr == OFS_DCFG1);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         power_and_clip_high_reg <= RST_POWER;
         digital_config_one_reg  <= RST_DCFG1;
      end
      else
      begin
         if (wr_power)
            power_and_clip_high_reg <= reg_wdata;
         if (wr_dcfg1)
            digital_config_one_reg <= reg_wdata;
      end
   end

   // Writes to the identifier fall through the decode and are dropped
   assign reg_rdata =
      (reg_addr == OFS_PART_ID) ? PART_ID_VALUE :
      (reg_addr == OFS_POWER)   ? power_and_clip_high_reg :
      (reg_addr == OFS_DCFG1)   ? digital_config_one_reg :
                                  READ_UNMAPPED;

   // Pin comes from outside the clock domain
   always_ff @(posedge clock)
   begin
      pin_sync_reg <= {pin_sync_reg[0], shutdown_control_n};
   end

   wire sleep_req    = power_and_clip_high_reg[SLEEP_BIT];
   wire shutdown_req = ~power_and_clip_high_reg[RUN_BIT] | ~pin_sync_reg[1];

   // Ramp step timer
   wire step_tick = (step_cnt_reg == 16'h0000);

   always_ff @(posedge clock)
   begin
      if (rst || step_tick)
         step_cnt_reg <= 16'(RAMP_STEP_CYCLES - 1);
      else
         step_cnt_reg <= step_cnt_reg - 16'h0001;
   end

   // Power sequencing; shutdown drops straight to the lowest state
   always_comb
   begin
      state_next = state_reg;
      gain_next  = gain_reg;
      if (shutdown_req)
      begin
         state_next = PWR_OFF;
         gain_next  = GAIN_ZERO;
      end
      else
      begin
         unique case (state_reg)
            PWR_ACTIVE:
               if (sleep_req)
                  state_next = PWR_RAMP;
               else if (step_tick && gain_reg != GAIN_FULL)
                  gain_next = gain_reg + 8'h01;
            PWR_RAMP:
               if (!sleep_req)
                  state_next = PWR_ACTIVE;
               else if (gain_reg == GAIN_ZERO)
                  state_next = PWR_SLEEP;
               else if (step_tick)
                  gain_next = gain_reg - 8'h01;
            PWR_SLEEP:
               if (!sleep_req)
                  state_next = PWR_ACTIVE;
            PWR_OFF:
               state_next = sleep_req ? PWR_SLEEP : PWR_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= PWR_ACTIVE;
         gain_reg  <= GAIN_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         gain_reg  <= gain_next;
      end
   end

   // Outputs follow the next state so they line up with the state register
   wire stage_on_next = (state_next == PWR_ACTIVE) | (state_next == PWR_RAMP);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stage_enable <= 1'b0;
         stage_hiz    <= 1'b1;
         core_awake   <= 1'b0;
         ramp_gain    <= GAIN_ZERO;
      end
      else
      begin
         stage_enable <= stage_on_next;
         stage_hiz    <= ~stage_on_next;
         core_awake   <= (state_next != PWR_OFF);
         ramp_gain    <= gain_next;
      end
   end

   // Clipper: threshold is an unsigned magnitude, so both signs are limited
   wire [CLIP_W-1:0]          threshold =
      {power_and_clip_high_reg[CLIP_HI_MSB:CLIP_HI_LSB], clip_low_bits};
   wire signed [SAMPLE_W:0]   thr_pos   = $signed({{(SAMPLE_W + 1 - CLIP_W){1'b0}}, threshold});
   wire signed [SAMPLE_W:0]   thr_neg   = -thr_pos;
   wire signed [SAMPLE_W:0]   sample_x  = {sample_in[SAMPLE_W-1], sample_in};
   wire signed [SAMPLE_W:0]   clipped   =
      (sample_x > thr_pos) ? thr_pos :
      (sample_x < thr_neg) ? thr_neg : sample_x;
   wire signed [SAMPLE_W+9:0] scaled    = clipped * $signed({1'b0, gain_reg});
   // Gain of all ones slightly attenuates; traded for a shift instead of a divide
   wire signed [SAMPLE_W-1:0] gained    = scaled[SAMPLE_W+7:8];

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sample_out       <= '0;
         sample_out_valid <= 1'b0;
      end
      else
      begin
         sample_out_valid <= sample_in_valid & (state_reg != PWR_OFF);
         if (sample_in_valid)
            sample_out <= gained;
      end
   end

   // Configuration one fields; reserved bits 5:4 are stored but steer nothing
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         highpass_skip        <= RST_DCFG1[HPS_BIT];
         slot_choice_source   <= RST_DCFG1[SLOT_SRC_BIT];
         rate_speed_select    <= RST_DCFG1[SPEED_BIT];
         serial_audio_framing <= RST_DCFG1[FRAME_MSB:FRAME_LSB];
      end
      else
      begin
         highpass_skip        <= digital_config_one_reg[HPS_BIT];
         slot_choice_source   <= digital_config_one_reg[SLOT_SRC_BIT];
         rate_speed_select    <= digital_config_one_reg[SPEED_BIT];
         serial_audio_framing <= digital_config_one_reg[FRAME_MSB:FRAME_LSB];
      end
   end

endmodule : amp_power_ident_registers
`default_nettype wire

//--- inc/amp_ctrl_pkg.sv
// Shared constants and state types for the amplifier control register bank
package amp_ctrl_pkg;

   // Register offsets
   localparam logic [7:0] OFS_PART_ID     = 8'h00;
   localparam logic [7:0] OFS_POWER       = 8'h01;
   localparam logic [7:0] OFS_DCFG1       = 8'h02;

   // Reset values
   localparam logic [7:0] RST_POWER       = 8'hFD;
   localparam logic [7:0] RST_DCFG1       = 8'h04;
   localparam logic [7:0] READ_UNMAPPED   = 8'h00;

   // Power control register fields
   localparam int         CLIP_HI_MSB     = 7;
   localparam int         CLIP_HI_LSB     = 2;
   localparam int         SLEEP_BIT       = 1;
   localparam int         RUN_BIT         = 0;
   localparam int         CLIP_HI_W       = CLIP_HI_MSB - CLIP_HI_LSB + 1;
   localparam int         CLIP_W          = 20;
   localparam int         CLIP_LO_W       = CLIP_W - CLIP_HI_W;

   // Digital configuration one fields
   localparam int         HPS_BIT         = 7;
   localparam int         SLOT_SRC_BIT    = 6;
   localparam int         SPEED_BIT       = 3;
   localparam int         FRAME_MSB       = 2;
   localparam int         FRAME_LSB       = 0;

   // Volume ramp timing
   localparam int         CLOCK_HZ        = 10_000_000;
   localparam int         RAMP_STEP_NS    = 1000;
   localparam int         RAMP_STEP_CYCLES =
      (RAMP_STEP_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] GAIN_FULL       = 8'hFF;
   localparam logic [7:0] GAIN_ZERO       = 8'h00;

   typedef enum logic [1:0]
   {
      PWR_ACTIVE = 2'b00,
      PWR_RAMP   = 2'b01,
      PWR_SLEEP  = 2'b11,
      PWR_OFF    = 2'b10
   } power_state_e;

   typedef enum logic [2:0]
   {
      I2C_IDLE      = 3'b000,
      I2C_ADDR      = 3'b001,
      I2C_ADDR_ACK  = 3'b011,
      I2C_WRITE     = 3'b010,
      I2C_WRITE_ACK = 3'b110,
      I2C_READ      = 3'b111,
      I2C_READ_ACK  = 3'b101
   } i2c_state_e;

endpackage : amp_ctrl_pkg

//--- src/i2c_reg_port.sv
// I2C target that turns serial transfers into register reads and writes
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_port
   import amp_ctrl_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = 7'h2C
)
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Serial pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe,
   // Register side
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_write,
   input  wire logic [7:0] reg_rdata
);

   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_q_reg;
   logic       sda_q_reg;
   i2c_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic       rw_reg;
   logic       first_reg;
   logic       nack_reg;

   wire scl_s     = scl_sync_reg[1];
   wire sda_s     = sda_sync_reg[1];
   wire scl_rise  = scl_s & ~scl_q_reg;
   wire scl_fall  = ~scl_s & scl_q_reg;
   wire bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   wire bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
   wire byte_done = (bit_cnt_reg == 4'h8);
   wire addr_hit  = (shift_reg[7:1] == TARGET_ADDR);

   always_ff @(posedge clock)
   begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_q_reg    <= scl_s;
      sda_q_reg    <= sda_s;
   end

   // Open-drain: only ever pulls low, so sda_out stays 0
   assign sda_out = 1'b0;

   always_ff @(posedge clock)
   begin
      reg_write <= 1'b0;
      if (rst)
      begin
         state_reg   <= I2C_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         rw_reg      <= 1'b0;
         first_reg   <= 1'b0;
         nack_reg    <= 1'b0;
         sda_oe      <= 1'b0;
         reg_addr    <= 8'h00;
         reg_wdata   <= 8'h00;
      end
      else if (bus_start)
      begin
         state_reg   <= I2C_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe      <= 1'b0;
      end
      else if (bus_stop)
      begin
         state_reg <= I2C_IDLE;
         sda_oe    <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (state_reg == I2C_ADDR || state_reg == I2C_WRITE)
         begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         else if (state_reg == I2C_READ)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         else if (state_reg == I2C_READ_ACK)
            nack_reg <= sda_s;
      end
      else if (scl_fall)
      begin
         unique case (state_reg)
            I2C_IDLE:
               sda_oe <= 1'b0;
            I2C_ADDR:
               if (byte_done)
               begin
                  state_reg <= addr_hit ? I2C_ADDR_ACK : I2C_IDLE;
                  sda_oe    <= addr_hit;
                  rw_reg    <= shift_reg[0];
               end
            I2C_ADDR_ACK:
            begin
               bit_cnt_reg <= 4'h0;
               first_reg   <= ~rw_reg;
               if (rw_reg)
               begin
                  state_reg <= I2C_READ;
                  tx_reg    <= reg_rdata;
                  sda_oe    <= ~reg_rdata[7];
                  reg_addr  <= reg_addr + 8'h01;
               end
               else
               begin
                  state_reg <= I2C_WRITE;
                  sda_oe    <= 1'b0;
               end
            end
            I2C_WRITE:
               if (byte_done)
               begin
                  state_reg <= I2C_WRITE_ACK;
                  sda_oe    <= 1'b1;
                  if (first_reg)
                     reg_addr <= shift_reg;
                  else
                  begin
                     reg_wdata <= shift_reg;
                     reg_write <= 1'b1;
                  end
               end
            I2C_WRITE_ACK:
            begin
               state_reg   <= I2C_WRITE;
               sda_oe      <= 1'b0;
               bit_cnt_reg <= 4'h0;
               if (!first_reg)
                  reg_addr <= reg_addr + 8'h01;
               first_reg <= 1'b0;
            end
            I2C_READ:
               if (byte_done)
               begin
                  state_reg <= I2C_READ_ACK;
                  sda_oe    <= 1'b0;
               end
               else
               begin
                  tx_reg <= {tx_reg[6:0], 1'b0};
                  sda_oe <= ~tx_reg[6];
               end
            I2C_READ_ACK:
            begin
               bit_cnt_reg <= 4'h0;
               if (nack_reg)
               begin
                  state_reg <= I2C_IDLE;
                  sda_oe    <= 1'b0;
               end
               else
               begin
                  state_reg <= I2C_READ;
                  tx_reg    <= reg_rdata;
                  sda_oe    <= ~reg_rdata[7];
                  reg_addr  <= reg_addr + 8'h01;
               end
            end
         endcase
      end
   end

endmodule : i2c_reg_port
`default_nettype wire

//--- dv/amp_ctrl_monitor.sv
// Port-level checks for the amplifier control register bank
`timescale 1ns/1ps
`default_nettype none
module amp_ctrl_monitor
   import amp_ctrl_pkg::*;
#(
   parameter int SAMPLE_W = 24
)
(
   // Clock and reset
   input wire logic                       clock,
   input wire logic                       rst,
   // Inputs seen by the bank
   input wire logic                       shutdown_control_n,
   input wire logic                       scl_in,
   input wire logic [CLIP_LO_W-1:0]       clip_low_bits,
   input wire logic                       sample_in_valid,
   // Outputs of the bank
   input wire logic                       sda_out,
   input wire logic                       sda_oe,
   input wire logic signed [SAMPLE_W-1:0] sample_out,
   input wire logic                       sample_out_valid,
   input wire logic                       stage_enable,
   input wire logic                       stage_hiz,
   input wire logic                       core_awake,
   input wire logic [7:0]                 ramp_gain,
   input wire logic [2:0]                 serial_audio_framing
);
   // Loosest bound the upper bits allow, so any register value passes
   wire logic signed [24:0] clip_lim = {5'h00, 6'h3F, clip_low_bits};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_hiz_inverse: assert property (stage_hiz == !stage_enable)
      else $error("stage hiz is not the inverse of stage enable");
   a_sleep_silent: assert property (core_awake && !stage_enable |-> ramp_gain == 8'h00)
      else $error("stage off while gain not zero");
   a_gain_step: assert property (core_awake && $past(core_awake) |->
      ramp_gain == $past(ramp_gain) || ramp_gain == $past(ramp_gain) + 8'h01
      || ramp_gain == $past(ramp_gain) - 8'h01)
      else $error("gain moved by more than one step");
   a_gain_hold: assert property ($changed(ramp_gain) && core_awake |=>
      ($stable(ramp_gain) || !core_awake) [*8])
      else $error("gain stepped too quickly");
   a_awake_stage: assert property (stage_enable |-> core_awake)
      else $error("stage powered while core asleep");
   a_pin_off: assert property (!shutdown_control_n [*6] |-> !core_awake && !stage_enable)
      else $error("shutdown pin did not stop the device");
   a_clip_bound: assert property (sample_out_valid |-> sample_out <= clip_lim && sample_out >= -clip_lim)
      else $error("sample beyond clip threshold");
   a_valid_cause: assert property (sample_out_valid |-> $past(sample_in_valid))
      else $error("output valid without input sample");
   a_cfg_reset: assert property ($fell(rst) |-> serial_audio_framing == 3'h4)
      else $error("framing not at default after reset");
   a_sda_pull_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_ack_on_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 3))
      else $error("data pin pulled while clock line high");
endmodule : amp_ctrl_monitor

bind amp_power_ident_registers amp_ctrl_monitor #(.SAMPLE_W(SAMPLE_W)) amp_ctrl_monitor_inst (.*);
`default_nettype wire

//--- dv/i2c_host_model.sv
// Bus host that performs register writes and reads over the serial pins
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
#(
   parameter logic [6:0] ADDR = 7'h2C
)
(
   // Clock for pacing
   input  wire logic clock,
   // Serial pins
   input  wire logic sda,
   output var  logic scl,
   output var  logic pull_low
);
   int nacks = 0;

   initial
   begin
      scl = 1'b1;
      pull_low = 1'b0;
   end

   // Six clocks a phase stays well clear of the synchroniser delay
   task automatic hp;
      repeat (6) @(negedge clock);
   endtask : hp

   // Data moves a clock after the clock line falls, never with it
   task automatic bit_x(input logic b, output logic r);
      @(negedge clock);
      pull_low = !b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
   endtask : bit_x

   task automatic byte_x(input logic [7:0] w, output logic [7:0] r, input logic nak_ok);
      logic a;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(w[i], r[i]);
      end
      bit_x(1'b1, a);
      if (a !== 1'b0 && !nak_ok)
      begin
         nacks++;
      end
   endtask : byte_x

   task automatic start;
      @(negedge clock);
      pull_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      pull_low = 1'b1;
      hp();
      scl = 1'b0;
   endtask : start

   task automatic stop;
      @(negedge clock);
      pull_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      pull_low = 1'b0;
      hp();
   endtask : stop

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start();
      byte_x({ADDR, 1'b0}, r, 1'b0);
      byte_x(a, r, 1'b0);
      byte_x(d, r, 1'b0);
      stop();
   endtask : wr

   // Two data bytes in one transfer exercise the pointer increment
   task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
      logic [7:0] r;
      start();
      byte_x({ADDR, 1'b0}, r, 1'b0);
      byte_x(a, r, 1'b0);
      byte_x(d0, r, 1'b0);
      byte_x(d1, r, 1'b0);
      stop();
   endtask : wr2

   // Final byte ends with a host NACK, so no acknowledge is expected
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      start();
      byte_x({ADDR, 1'b0}, r, 1'b0);
      byte_x(a, r, 1'b0);
      start();
      byte_x({ADDR, 1'b1}, r, 1'b0);
      byte_x(8'hFF, d, 1'b1);
      stop();
   endtask : rd
endmodule : i2c_host_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import amp_ctrl_pkg::*;
;
   localparam logic [7:0] ID = 8'hA5;  // Arbitrary identifier value
   logic                  clock = 1'b0;
   logic                  rst = 1'b1;
   logic                  shutdown_control_n = 1'b1;
   logic [CLIP_LO_W-1:0]  clip_low_bits = '0;
   logic signed [23:0]    sample_in = '0;
   logic                  sample_in_valid = 1'b0;
   logic                  sda_out;
   logic                  sda_oe;
   logic signed [23:0]    sample_out;
   logic                  sample_out_valid;
   logic                  stage_enable;
   logic                  stage_hiz;
   logic                  core_awake;
   logic [7:0]            ramp_gain;
   logic                  highpass_skip;
   logic                  slot_choice_source;
   logic                  rate_speed_select;
   logic [2:0]            serial_audio_framing;
   wire  logic            scl;
   wire  logic            host_low;
   wire  logic            sda = !(sda_oe || host_low);
   int                    failures = 0;
   int                    samples_checked = 0;
   int                    cycles = 0;

   amp_power_ident_registers amp_power_ident_registers_inst (.*, .scl_in(scl), .sda_in(sda));
   i2c_host_model i2c_host_model_inst (.clock, .sda, .scl, .pull_low(host_low));

   initial
   begin
      forever #50 clock = !clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i2c_host_model_inst.wr(a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
      logic [7:0] d;
      i2c_host_model_inst.rd(a, d);
      check(n, {16'h0000, e}, {16'h0000, d});
   endtask : rd_chk

   task automatic feed(input logic [23:0] s, input logic [23:0] e);
      sample_in = s;
      sample_in_valid = 1'b1;
      @(negedge clock);
      sample_in_valid = 1'b0;
      check("out valid", 24'h1, {23'h0, sample_out_valid});
      check("sample", e, sample_out);
      // Let an edge pass so a following feed never re-raises valid in this step
      @(negedge clock);
      check("out drop", 24'h0, {23'h0, sample_out_valid});
   endtask : feed

   task automatic t_ident;
      rd_chk(OFS_PART_ID, ID, "id");
      rd_chk(OFS_POWER, 8'hFD, "power");
      rd_chk(OFS_DCFG1, 8'h04, "cfg1");
      wr(OFS_PART_ID, 8'h5A);
      rd_chk(OFS_PART_ID, ID, "id");
      rd_chk(8'h07, 8'h00, "unmapped");
      $display("test ident done");
   endtask : t_ident

   task automatic t_config;
      logic [7:0] v [2] = '{8'hCA, 8'h05};
      i2c_host_model_inst.wr2(OFS_POWER, 8'hFD, 8'h81);
      rd_chk(OFS_DCFG1, 8'h81, "cfg1 burst");
      foreach (v[i])
      begin
         wr(OFS_DCFG1, v[i]);
         check("skip", {23'h0, v[i][7]}, {23'h0, highpass_skip});
         check("source", {23'h0, v[i][6]}, {23'h0, slot_choice_source});
         check("speed", {23'h0, v[i][3]}, {23'h0, rate_speed_select});
         check("framing", {21'h0, v[i][2:0]}, {21'h0, serial_audio_framing});
         rd_chk(OFS_DCFG1, v[i], "cfg1");
      end
      $display("test config done");
   endtask : t_config

   task automatic t_clip;
      clip_low_bits = 14'h0010;
      wr(OFS_POWER, 8'h05);
      for (int i = 0; i < 3000 && ramp_gain !== 8'hFF; i++)
      begin
         @(negedge clock);
      end
      feed(24'h100000, 24'h003FCF);
      feed(24'hF00000, 24'hFFC030);
      feed(24'h000100, 24'h0000FF);
      $display("test clip done");
   endtask : t_clip

   task automatic t_sleep;
      wr(OFS_POWER, 8'h07);
      for (int i = 0; i < 3000 && stage_enable !== 1'b0; i++)
      begin
         @(negedge clock);
      end
      check("gain", 24'h0, {16'h0, ramp_gain});
      check("hiz", 24'h1, {23'h0, stage_hiz});
      check("awake", 24'h1, {23'h0, core_awake});
      feed(24'h000100, 24'h000000);
      wr(OFS_POWER, 8'h05);
      check("stage", 24'h1, {23'h0, stage_enable});
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_shutdown;
      wr(OFS_POWER, 8'h04);
      check("awake", 24'h0, {23'h0, core_awake});
      check("stage", 24'h0, {23'h0, stage_enable});
      rd_chk(OFS_POWER, 8'h04, "power");
      rd_chk(OFS_DCFG1, 8'h05, "cfg1");
      wr(OFS_POWER, 8'h07);
      check("stage", 24'h0, {23'h0, stage_enable});
      check("awake", 24'h1, {23'h0, core_awake});
      wr(OFS_POWER, 8'h05);
      check("awake", 24'h1, {23'h0, core_awake});
      shutdown_control_n = 1'b0;
      repeat (8) @(negedge clock);
      check("awake", 24'h0, {23'h0, core_awake});
      rd_chk(OFS_POWER, 8'h05, "power");
      shutdown_control_n = 1'b1;
      check("nacks", 24'h0, 24'(i2c_host_model_inst.nacks));
      $display("test shutdown done");
   endtask : t_shutdown

   task automatic t_rereset;
      rst = 1'b1;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      rd_chk(OFS_POWER, 8'hFD, "power");
      rd_chk(OFS_DCFG1, 8'h04, "cfg1");
      $display("test rereset done");
   endtask : t_rereset

   initial
   begin
      repeat (4) @(negedge clock);
      rst = 1'b0;
      repeat (2) @(negedge clock);
      t_ident();
      t_config();
      t_clip();
      t_sleep();
      t_shutdown();
      t_rereset();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
